// ---- dlgc_defines.svh ----
// Offsets, field positions, reset values and lookup tables of the gain block.
`ifndef DLGC_DEFINES_SVH
`define DLGC_DEFINES_SVH

`define DLGC_ADDR_W          6
`define DLGC_OFF_BIT_SYNC    6'h1A
`define DLGC_OFF_GAIN_LIMITS 6'h1B

`define DLGC_RST_BIT_SYNC    8'h6C
`define DLGC_RST_GAIN_LIMITS 8'h03

`define DLGC_PRE_KI_MSB      7
`define DLGC_PRE_KI_LSB      6
`define DLGC_PRE_KP_MSB      5
`define DLGC_PRE_KP_LSB      4
`define DLGC_POST_KI_BIT     3
`define DLGC_POST_KP_BIT     2
`define DLGC_LIMIT_MSB       1
`define DLGC_LIMIT_LSB       0

`define DLGC_DGAIN_MSB       7
`define DLGC_DGAIN_LSB       6
`define DLGC_AMP_CAP_MSB     5
`define DLGC_AMP_CAP_LSB     3
`define DLGC_TARGET_MSB      2
`define DLGC_TARGET_LSB      0

// Integral gain is expressed in units of half the base gain.
`define DLGC_KI_HALF         4'h1
// Proportional gain is expressed in units of the base gain.
`define DLGC_KP_BASE         3'h1

// Rate limit in units of 1/32 of the data rate, indexed by the field.
`define DLGC_LIMIT_TABLE     {3'h4, 3'h2, 3'h1, 3'h0}
// Front amplifier cap in tenths of a dB below maximum, indexed by the field.
`define DLGC_AMP_CAP_TABLE   {8'hAB, 8'h92, 8'h73, 8'h5C, \
                              8'h4A, 8'h3D, 8'h1A, 8'h00}
// Channel filter amplitude target in dB, indexed by the field.
`define DLGC_TARGET_TABLE    {6'h2A, 6'h28, 6'h26, 6'h24, \
                              6'h21, 6'h1E, 6'h1B, 6'h18}

`endif

// ---- dlgc_pkg.sv ----
// Types shared by the demodulator loop gain configuration block.
package dlgc_pkg;

    typedef enum logic {
        DLGC_PRESYNC,
        DLGC_POSTSYNC
    } dlgc_phase_e;

    typedef logic [7:0] dlgc_reg_t;

endpackage : dlgc_pkg

// ---- dlgc_regs.sv ----
// Loop gain and gain control limit registers with decoded settings.
//
// Summary of operation
// - Pre-sync integral gain is field plus one.
// - Pre-sync proportional gain is field plus one.
// - Post-sync integral: keep pre value or half.
// - Post-sync proportional: keep pre value or base.
// - Rate offset limit: off, 3.125, 6.25, 12.5.
// - Digital gain cap removes top N steps.
// - Front amplifier cap lowers combined gain.
// - Amplitude target maps field to dB.
// - Gated loops freeze until carrier sense.
`timescale 1ns/1ns
`default_nettype none
`include "dlgc_defines.svh"

module dlgc_regs #(
    parameter logic [2:0] DGAIN_TOP_STEP = 3'h7
) (
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic [`DLGC_ADDR_W-1:0] reg_addr_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    input  wire dlgc_pkg::dlgc_reg_t     reg_wdata_i,
    output var  dlgc_pkg::dlgc_reg_t     reg_rdata_o,
    input  wire logic                    sync_detected_i,
    input  wire logic                    rx_start_i,
    input  wire logic                    carrier_gate_en_i,
    input  wire logic                    carrier_sense_i,
    output var  logic [3:0]              integral_gain_o,
    output var  logic [2:0]              proportional_gain_o,
    output var  logic [2:0]              rate_limit_o,
    output var  logic                    loop_freeze_o,
    output var  logic [2:0]              digital_gain_max_o,
    output var  logic [7:0]              amp_gain_cap_o,
    output var  logic [5:0]              amplitude_target_o,
    output var  logic                    postsync_o
);
    import dlgc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register file.

    dlgc_reg_t   bit_sync_loop_config_q;
    dlgc_reg_t   bit_sync_loop_config_d;
    dlgc_reg_t   gain_control_limits_q;
    dlgc_reg_t   gain_control_limits_d;
    dlgc_reg_t   rdata_q;
    dlgc_reg_t   rdata_d;

    // Writes land on the next edge; a read in the same cycle sees the old
    // contents, and an unmapped address reads as zero.
    always_comb begin
        bit_sync_loop_config_d = bit_sync_loop_config_q;
        gain_control_limits_d  = gain_control_limits_q;
        rdata_d                = rdata_q;
        if (reg_wr_i && reg_addr_i == `DLGC_OFF_BIT_SYNC) begin
            bit_sync_loop_config_d = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == `DLGC_OFF_GAIN_LIMITS) begin
            gain_control_limits_d = reg_wdata_i;
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `DLGC_OFF_BIT_SYNC:    rdata_d = bit_sync_loop_config_q;
                `DLGC_OFF_GAIN_LIMITS: rdata_d = gain_control_limits_q;
                default:               rdata_d = 8'h00;
            endcase
        end
    end

    // Registers of the register file.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bit_sync_loop_config_q <= `DLGC_RST_BIT_SYNC;
            gain_control_limits_q  <= `DLGC_RST_GAIN_LIMITS;
            rdata_q                <= 8'h00;
        end else begin
            bit_sync_loop_config_q <= bit_sync_loop_config_d;
            gain_control_limits_q  <= gain_control_limits_d;
            rdata_q                <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Field extraction.

    logic [1:0] pre_ki;
    logic [1:0] pre_kp;
    logic       post_ki;
    logic       post_kp;
    logic [1:0] limit_sel;
    logic [1:0] dgain_cap;
    logic [2:0] amp_cap_sel;
    logic [2:0] target_sel;
    logic [11:0] limit_table;
    logic [63:0] amp_cap_table;
    logic [47:0] target_table;

    // Fields are decoded from the live registers, so a write steers the
    // loops from the edge after it.
    assign pre_ki      =
        bit_sync_loop_config_q[`DLGC_PRE_KI_MSB:`DLGC_PRE_KI_LSB];
    assign pre_kp      =
        bit_sync_loop_config_q[`DLGC_PRE_KP_MSB:`DLGC_PRE_KP_LSB];
    assign post_ki     = bit_sync_loop_config_q[`DLGC_POST_KI_BIT];
    assign post_kp     = bit_sync_loop_config_q[`DLGC_POST_KP_BIT];
    assign limit_sel   =
        bit_sync_loop_config_q[`DLGC_LIMIT_MSB:`DLGC_LIMIT_LSB];
    assign dgain_cap   =
        gain_control_limits_q[`DLGC_DGAIN_MSB:`DLGC_DGAIN_LSB];
    assign amp_cap_sel =
        gain_control_limits_q[`DLGC_AMP_CAP_MSB:`DLGC_AMP_CAP_LSB];
    assign target_sel  =
        gain_control_limits_q[`DLGC_TARGET_MSB:`DLGC_TARGET_LSB];
    assign limit_table   = `DLGC_LIMIT_TABLE;
    assign amp_cap_table = `DLGC_AMP_CAP_TABLE;
    assign target_table  = `DLGC_TARGET_TABLE;

    ////////////////////////////////////////////////////////////////////////
    // Reception phase and decoded loop settings.

    dlgc_phase_e phase_q;
    dlgc_phase_e phase_d;
    logic [3:0]  ki_q;
    logic [3:0]  ki_d;
    logic [2:0]  kp_q;
    logic [2:0]  kp_d;
    logic [2:0]  limit_q;
    logic [2:0]  limit_d;
    logic        freeze_q;
    logic        freeze_d;
    logic [2:0]  dgain_q;
    logic [2:0]  dgain_d;
    logic [7:0]  amp_cap_q;
    logic [7:0]  amp_cap_d;
    logic [5:0]  target_q;
    logic [5:0]  target_d;

    // A new reception wins over a sync flagged in the same cycle, since the
    // sync then belongs to the frame being abandoned.
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            DLGC_PRESYNC: begin
                if (sync_detected_i && !rx_start_i) begin
                    phase_d = DLGC_POSTSYNC;
                end
            end
            DLGC_POSTSYNC: begin
                if (rx_start_i) begin
                    phase_d = DLGC_PRESYNC;
                end
            end
        endcase
        // Gains follow the next phase so they switch on the sync edge.
        ki_d = {1'b0, pre_ki, 1'b0} + 4'h2;
        kp_d = {1'b0, pre_kp} + 3'h1;
        if (phase_d == DLGC_POSTSYNC && post_ki) begin
            ki_d = `DLGC_KI_HALF;
        end
        if (phase_d == DLGC_POSTSYNC && post_kp) begin
            kp_d = `DLGC_KP_BASE;
        end
        limit_d   = limit_table[limit_sel*3 +: 3];
        freeze_d  = carrier_gate_en_i && !carrier_sense_i;
        dgain_d   = DGAIN_TOP_STEP - {1'b0, dgain_cap};
        amp_cap_d = amp_cap_table[amp_cap_sel*8 +: 8];
        target_d  = target_table[target_sel*6 +: 6];
    end

    // Decoded settings are registered so every output comes from a flop.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_q   <= DLGC_PRESYNC;
            ki_q      <= 4'h4;
            kp_q      <= 3'h3;
            limit_q   <= 3'h0;
            freeze_q  <= 1'b0;
            dgain_q   <= DGAIN_TOP_STEP;
            amp_cap_q <= 8'h00;
            target_q  <= 6'h21;
        end else begin
            phase_q   <= phase_d;
            ki_q      <= ki_d;
            kp_q      <= kp_d;
            limit_q   <= limit_d;
            freeze_q  <= freeze_d;
            dgain_q   <= dgain_d;
            amp_cap_q <= amp_cap_d;
            target_q  <= target_d;
        end
    end

    assign integral_gain_o     = ki_q;
    assign proportional_gain_o = kp_q;
    assign rate_limit_o        = limit_q;
    assign loop_freeze_o       = freeze_q;
    assign digital_gain_max_o  = dgain_q;
    assign amp_gain_cap_o      = amp_cap_q;
    assign amplitude_target_o  = target_q;
    assign postsync_o          = (phase_q == DLGC_POSTSYNC);

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_pre_ki;
        @(posedge clk_i) disable iff (sys_rst_i)
        (phase_d == DLGC_PRESYNC) |=>
            integral_gain_o == {1'b0, $past(pre_ki), 1'b0} + 4'h2;
    endproperty
    a_pre_ki: assert property (p_pre_ki)
        else $error("Pre-sync integral gain wrong.");

    property p_pre_kp;
        @(posedge clk_i) disable iff (sys_rst_i)
        (phase_d == DLGC_PRESYNC) |=>
            proportional_gain_o == {1'b0, $past(pre_kp)} + 3'h1;
    endproperty
    a_pre_kp: assert property (p_pre_kp)
        else $error("Pre-sync proportional gain wrong.");

    property p_post_ki;
        @(posedge clk_i) disable iff (sys_rst_i)
        (phase_d == DLGC_POSTSYNC) |=> postsync_o &&
            integral_gain_o == ($past(post_ki) ? 4'h1
                : {1'b0, $past(pre_ki), 1'b0} + 4'h2);
    endproperty
    a_post_ki: assert property (p_post_ki)
        else $error("Post-sync integral gain wrong.");

    property p_post_kp;
        @(posedge clk_i) disable iff (sys_rst_i)
        (phase_d == DLGC_POSTSYNC) |=>
            proportional_gain_o == ($past(post_kp) ? 3'h1
                : {1'b0, $past(pre_kp)} + 3'h1);
    endproperty
    a_post_kp: assert property (p_post_kp)
        else $error("Post-sync proportional gain wrong.");

    property p_limit;
        @(posedge clk_i) disable iff (sys_rst_i)
        ##1 rate_limit_o == ($past(limit_sel) == 2'h3 ? 3'h4
            : {1'b0, $past(limit_sel)});
    endproperty
    a_limit: assert property (p_limit)
        else $error("Rate offset limit wrong.");

    property p_dgain;
        @(posedge clk_i) disable iff (sys_rst_i)
        ##1 digital_gain_max_o + {1'b0, $past(dgain_cap)} == DGAIN_TOP_STEP;
    endproperty
    a_dgain: assert property (p_dgain)
        else $error("Digital gain cap wrong.");

    property p_amp_cap;
        @(posedge clk_i) disable iff (sys_rst_i)
        ($past(amp_cap_sel) == 3'h7) && !$past(sys_rst_i) |->
            amp_gain_cap_o == 8'hAB;
    endproperty
    a_amp_cap: assert property (p_amp_cap)
        else $error("Front amplifier cap wrong.");

    property p_target;
        @(posedge clk_i) disable iff (sys_rst_i)
        (target_sel == 3'h0) ##1 (target_sel == 3'h0) |->
            amplitude_target_o == 6'h18;
    endproperty
    a_target: assert property (p_target)
        else $error("Amplitude target wrong.");

    property p_freeze;
        @(posedge clk_i) disable iff (sys_rst_i)
        (carrier_gate_en_i && !carrier_sense_i) |=> loop_freeze_o;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("Loops not frozen while gated.");

    property p_restart;
        @(posedge clk_i) disable iff (sys_rst_i)
        rx_start_i |=> !postsync_o;
    endproperty
    a_restart: assert property (p_restart)
        else $error("New reception kept post-sync gains.");

endmodule : dlgc_regs
`default_nettype wire

// ---- dlgc_regs_bench.sv ----
// Self-checking bench for the loop gain and gain limit registers.
`timescale 1ns/1ns
`default_nettype none
`include "dlgc_defines.svh"

module dlgc_regs_bench;
    import dlgc_pkg::*;

    logic       clk_i;
    logic       sys_rst_i;
    logic [5:0] reg_addr_i;
    logic       reg_wr_i;
    logic       reg_rd_i;
    dlgc_reg_t  reg_wdata_i;
    dlgc_reg_t  reg_rdata_o;
    logic       sync_detected_i;
    logic       rx_start_i;
    logic       carrier_gate_en_i;
    logic       carrier_sense_i;
    logic [3:0] integral_gain_o;
    logic [2:0] proportional_gain_o;
    logic [2:0] rate_limit_o;
    logic       loop_freeze_o;
    logic [2:0] digital_gain_max_o;
    logic [7:0] amp_gain_cap_o;
    logic [5:0] amplitude_target_o;
    logic       postsync_o;
    int         fail_count = 0;
    int         n_compared = 0;
    int         cycles     = 0;

    // Expected decodes, written out from the field tables.
    logic [7:0] lim [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
    logic [7:0] amp [8] = '{8'h00, 8'h1A, 8'h3D, 8'h4A,
                            8'h5C, 8'h73, 8'h92, 8'hAB};
    logic [7:0] tgt [8] = '{8'h18, 8'h1B, 8'h1E, 8'h21,
                            8'h24, 8'h26, 8'h28, 8'h2A};

    dlgc_regs dlgc_regs_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .sync_detected_i(sync_detected_i), .rx_start_i(rx_start_i),
        .carrier_gate_en_i(carrier_gate_en_i),
        .carrier_sense_i(carrier_sense_i),
        .integral_gain_o(integral_gain_o),
        .proportional_gain_o(proportional_gain_o),
        .rate_limit_o(rate_limit_o), .loop_freeze_o(loop_freeze_o),
        .digital_gain_max_o(digital_gain_max_o),
        .amp_gain_cap_o(amp_gain_cap_o),
        .amplitude_target_o(amplitude_target_o), .postsync_o(postsync_o));

    // The clock toggles every half period of 2 ns.
    always #2 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks; all driving happens at the falling edge.

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask : wr

    // Read data stands one cycle after the read edge; an idle edge follows
    // so the next request never reuses a strobe in the same time step.
    task automatic rd(input logic [5:0] a, input logic [7:0] e,
                      input string name);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        chk(name, e, reg_rdata_o);
        @(negedge clk_i);
    endtask : rd

    // Phase outputs stand until the next event, so the idle edge is harmless.
    task automatic ev(input logic s, input logic r);
        sync_detected_i = s;
        rx_start_i = r;
        @(negedge clk_i);
        sync_detected_i = 1'b0;
        rx_start_i = 1'b0;
        @(negedge clk_i);
    endtask : ev

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.

    // Reset is held for ten cycles; every output must show its reset value.
    task automatic t_reset();
        sys_rst_i = 1'b1;
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        chk("rdata", 8'h00, reg_rdata_o);
        chk("integral", 8'h04, 8'(integral_gain_o));
        chk("proportional", 8'h03, 8'(proportional_gain_o));
        chk("rate limit", 8'h00, 8'(rate_limit_o));
        chk("freeze", 8'h00, 8'(loop_freeze_o));
        chk("digital max", 8'h07, 8'(digital_gain_max_o));
        chk("amp cap", 8'h00, amp_gain_cap_o);
        chk("target", 8'h21, 8'(amplitude_target_o));
        chk("postsync", 8'h00, 8'(postsync_o));
        rd(`DLGC_OFF_BIT_SYNC, 8'h6C, "bit sync reset");
        rd(`DLGC_OFF_GAIN_LIMITS, 8'h03, "limits reset");
    endtask : t_reset

    // A write to an unmapped place must change nothing and read as zero.
    task automatic t_unmapped();
        wr(6'h3F, 8'hFF);
        rd(6'h3F, 8'h00, "unmapped read");
        rd(`DLGC_OFF_BIT_SYNC, 8'h6C, "bit sync kept");
        rd(`DLGC_OFF_GAIN_LIMITS, 8'h03, "limits kept");
    endtask : t_unmapped

    // Every gain code, before and after sync, with both post choices.
    task automatic t_bit_sync();
        logic [1:0] v;
        logic [7:0] d;
        logic [7:0] ki;
        logic [7:0] kp;
        for (int i = 0; i < 4; i++) begin
            v = 2'(i);
            d = {v, ~v, v[0], v[1], v};
            ki = 8'(2 * (i + 1));
            kp = 8'(4 - i);
            wr(`DLGC_OFF_BIT_SYNC, d);
            @(negedge clk_i);
            rd(`DLGC_OFF_BIT_SYNC, d, "bit sync readback");
            chk("integral pre", ki, 8'(integral_gain_o));
            chk("proportional pre", kp, 8'(proportional_gain_o));
            chk("rate limit", lim[i], 8'(rate_limit_o));
            ev(1'b1, 1'b0);
            chk("postsync", 8'h01, 8'(postsync_o));
            chk("integral post", v[0] ? 8'h01 : ki,
                8'(integral_gain_o));
            chk("proportional post", v[1] ? 8'h01 : kp,
                8'(proportional_gain_o));
            ev(1'b1, 1'b0);
            chk("postsync again", 8'h01, 8'(postsync_o));
            ev(1'b0, 1'b1);
            chk("postsync left", 8'h00, 8'(postsync_o));
            chk("integral back", ki, 8'(integral_gain_o));
            ev(1'b1, 1'b1);
            chk("start wins", 8'h00, 8'(postsync_o));
            chk("proportional kept", kp, 8'(proportional_gain_o));
        end
    endtask : t_bit_sync

    // Every code of the three gain control fields.
    task automatic t_limits();
        logic [2:0] v;
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            d = {v[1:0], v, ~v};
            wr(`DLGC_OFF_GAIN_LIMITS, d);
            @(negedge clk_i);
            rd(`DLGC_OFF_GAIN_LIMITS, d, "limits readback");
            chk("digital max", 8'(7 - (i % 4)),
                8'(digital_gain_max_o));
            chk("amp cap", amp[i], amp_gain_cap_o);
            chk("target", tgt[7 - i], 8'(amplitude_target_o));
        end
    endtask : t_limits

    // The loops stay frozen only while gated and carrier sense is low.
    task automatic t_freeze();
        for (int i = 0; i < 4; i++) begin
            carrier_gate_en_i = i[1];
            carrier_sense_i = i[0];
            @(negedge clk_i);
            chk("freeze", 8'(i[1] & ~i[0]), 8'(loop_freeze_o));
        end
        carrier_gate_en_i = 1'b0;
    endtask : t_freeze

    ////////////////////////////////////////////////////////////////////////
    // A hang is cut short well past the roughly 120 cycles the run needs.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        clk_i = 1'b0;
        sys_rst_i = 1'b1;
        reg_addr_i = 6'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wdata_i = 8'h00;
        sync_detected_i = 1'b0;
        rx_start_i = 1'b0;
        carrier_gate_en_i = 1'b0;
        carrier_sense_i = 1'b0;
        t_reset();
        t_unmapped();
        t_bit_sync();
        t_limits();
        t_freeze();
        ev(1'b1, 1'b0);
        t_reset();
        summarize();
    end

endmodule : dlgc_regs_bench
`default_nettype wire
